// [hw/aagc_top.sv]
// record path control: registers, sample clock, decimation, gain loop
// assumes a synchronous register port and an asynchronous modulator bit pin
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module aagc_top #(
  parameter int unsigned MS_CYCLES = aagc_pkg::MS_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [aagc_pkg::ADDR_W-1:0] i_addr,
  input wire logic [aagc_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_mod_bit,
  output logic [aagc_pkg::DATA_W-1:0] o_rdata,
  output logic [1:0] o_mux_sel,
  output logic o_bias_en,
  output logic o_bias_hi,
  output logic o_analog_en,
  output logic [7:0] o_pga_gain,
  output logic o_adc_pd_done,
  output logic [15:0] o_sample,
  output logic o_sample_valid
);
  import aagc_pkg::*;

  // register state
  logic [7:0] agc_ctl_ff;
  logic [1:0] noise_sel_ff;
  logic clip_en_ff;
  logic soft_off_ff;
  logic [1:0] hyst_ff;
  logic [6:0] max_gain_ff;
  logic [2:0] deb_ns_ff;
  logic [2:0] deb_sn_ff;
  logic [DATA_W-1:0] path_ff;
  logic [DATA_W-1:0] pll_ff;
  logic [FRAC_W-1:0] frac_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;

  // loop state
  aagc_mode_t mode_ff;
  logic [6:0] agc_gain_ff;
  logic [8:0] deb_ff;
  logic noise_flag_ff;
  logic sat_ff;
  logic [23:0] atk_cnt_ff;
  logic [23:0] dcy_cnt_ff;

  // clocking and conversion state
  logic mod_meta_ff;
  logic mod_sync_ff;
  logic [21:0] acc_ff;
  logic [4:0] qdiv_ff;
  logic os_tick_ff;
  logic [6:0] os_cnt_ff;
  logic [7:0] ones_ff;
  logic fs_tick_ff;
  logic [15:0] raw_ff;
  logic [15:0] dly_ff [DECIM_DELAY];
  logic pd_done_ff;
  logic analog_en_ff;
  logic [1:0] mux_ff;
  logic bias_en_ff;
  logic bias_hi_ff;

  logic agc_en;
  logic [6:0] req_gain;
  logic [15:0] avg;
  logic clip;
  logic [15:0] tgt_lvl;
  logic [15:0] thr_lo;
  logic [15:0] thr_hi;
  logic [23:0] atk_period;
  logic [23:0] dcy_period;
  logic [8:0] lim_ns;
  logic [8:0] lim_sn;
  logic too_loud;
  logic too_weak;
  logic atk_due;
  logic dcy_due;
  logic [19:0] k_val;
  logic [21:0] pll_thr;
  logic [21:0] acc_sum;
  logic [4:0] q_last;
  logic [7:0] ones_nxt;
  logic [8:0] centred;
  logic [15:0] pcm;
  logic [7:0] step_target;

  aagc_step_if step_if ();

  aagc_stepper u_stepper (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .s(step_if.stp)
  );

  aagc_absavg u_absavg (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_valid(fs_tick_ff),
    .i_sample(raw_ff),
    .o_avg(avg),
    .o_clip(clip)
  );

  // register writes; unmapped and read-only offsets ignore writes
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      agc_ctl_ff <= 8'h00;
      noise_sel_ff <= 2'h0;
      clip_en_ff <= 1'b0;
      soft_off_ff <= 1'b0;
      hyst_ff <= 2'h0;
      max_gain_ff <= GAIN_MAX;
      deb_ns_ff <= 3'h0;
      deb_sn_ff <= 3'h0;
      path_ff <= RST_PATH;
      pll_ff <= RST_PLL;
      frac_ff <= 14'h0000;
    end else if (i_wr) begin
      case (i_addr)
        ADDR_AGC: agc_ctl_ff <= i_wdata[7:0];
        ADDR_NOISE: begin
          noise_sel_ff <= i_wdata[NZ_THR_LSB +: 2];
          clip_en_ff <= i_wdata[NZ_CLIP_B];
        end
        ADDR_SOFT: begin
          soft_off_ff <= i_wdata[SOFT_OFF_B];
          hyst_ff <= i_wdata[SOFT_HYST_LSB +: 2];
        end
        ADDR_DEB: begin
          max_gain_ff <= i_wdata[DEB_MAX_LSB +: 7];
          deb_ns_ff <= i_wdata[DEB_NS_LSB +: 3];
          deb_sn_ff <= i_wdata[DEB_SN_LSB +: 3];
        end
        ADDR_PATH: path_ff <= i_wdata;
        ADDR_PLL: pll_ff <= i_wdata;
        ADDR_FRAC: frac_ff <= i_wdata[FRAC_W-1:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    nxt_rdata = '0;
    case (i_addr)
      ADDR_AGC: nxt_rdata = {1'b0, agc_gain_ff, agc_ctl_ff};
      ADDR_FLAGS: begin
        // D0 shows saturation while the loop runs, settled gain otherwise
        nxt_rdata[FLG_SAT_B] = agc_en ? sat_ff : step_if.settled;
        nxt_rdata[FLG_PD_B] = pd_done_ff;
        nxt_rdata[FLG_NOISE_B] = noise_flag_ff;
      end
      ADDR_NOISE: begin
        nxt_rdata[NZ_THR_LSB +: 2] = noise_sel_ff;
        nxt_rdata[NZ_CLIP_B] = clip_en_ff;
      end
      ADDR_SOFT: begin
        nxt_rdata[SOFT_OFF_B] = soft_off_ff;
        nxt_rdata[SOFT_HYST_LSB +: 2] = hyst_ff;
      end
      ADDR_DEB: nxt_rdata = {max_gain_ff, deb_ns_ff, deb_sn_ff, 3'h0};
      ADDR_PATH: nxt_rdata = path_ff;
      ADDR_PLL: nxt_rdata = pll_ff;
      ADDR_FRAC: nxt_rdata = {2'h0, frac_ff};
      default: nxt_rdata = '0;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= i_rd ? nxt_rdata : '0;
    end
  end

  // modulator bit arrives from the analog side, so it is synchronised first
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mod_meta_ff <= 1'b0;
      mod_sync_ff <= 1'b0;
    end else begin
      mod_meta_ff <= i_mod_bit;
      mod_sync_ff <= mod_meta_ff;
    end
  end

  // oversampling tick at 128 Fsref; a ratio above one tick per clock is not
  // reachable at this clock, so the accumulator then runs slow
  always_comb begin
    k_val = 20'(32'(pll_ff[PLL_J_LSB +: 7]) * FRAC_SCALE + 32'(frac_ff));
    pll_thr = 22'(32'(pll_ff[PLL_P_LSB +: 4]) * (PLL_DIV / OSR) * FRAC_SCALE);
    acc_sum = acc_ff + {2'h0, k_val};
    q_last = 5'(32'(pll_ff[PLL_Q_LSB +: 4]) + Q_BIAS - 1);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc_ff <= '0;
      qdiv_ff <= '0;
      os_tick_ff <= 1'b0;
    end else if (pd_done_ff) begin
      acc_ff <= '0;
      qdiv_ff <= '0;
      os_tick_ff <= 1'b0;
    end else if (pll_ff[PLL_EN_B]) begin
      os_tick_ff <= (acc_sum >= pll_thr);
      acc_ff <= (acc_sum >= pll_thr) ? acc_sum - pll_thr : acc_sum;
    end else begin
      os_tick_ff <= (qdiv_ff == q_last);
      qdiv_ff <= (qdiv_ff == q_last) ? 5'h00 : qdiv_ff + 5'h01;
    end
  end

  // decimation: integrate 128 modulator bits and dump once per sample
  assign ones_nxt = ones_ff + {7'h00, mod_sync_ff};
  assign centred = {1'b0, ones_nxt} - {1'b0, ONES_MID};
  assign pcm = (ones_nxt > {ONES_MID[6:0], 1'b0} - 8'h01) ? FULL_POS : {centred[6:0], 9'h000};

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      os_cnt_ff <= '0;
      ones_ff <= '0;
      fs_tick_ff <= 1'b0;
      raw_ff <= '0;
    end else begin
      fs_tick_ff <= 1'b0;
      if (os_tick_ff) begin
        if (os_cnt_ff == 7'(OSR - 1)) begin
          os_cnt_ff <= '0;
          ones_ff <= '0;
          raw_ff <= pcm;
          fs_tick_ff <= 1'b1;
        end else begin
          os_cnt_ff <= os_cnt_ff + 7'h01;
          ones_ff <= ones_nxt;
        end
      end
    end
  end

  // fixed delay line keeps the output latency at the linear-phase figure
  generate
    for (genvar i = 0; i < DECIM_DELAY; i++) begin : g_dly
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          dly_ff[i] <= '0;
        end else if (fs_tick_ff) begin
          dly_ff[i] <= (i == 0) ? raw_ff : dly_ff[(i == 0) ? 0 : i - 1];
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sample <= '0;
      o_sample_valid <= 1'b0;
    end else begin
      // a sample in flight at power-down is dropped
      o_sample_valid <= fs_tick_ff && !pd_done_ff;
      if (fs_tick_ff && !pd_done_ff) begin
        o_sample <= dly_ff[DECIM_DELAY-1];
      end
    end
  end

  // loop thresholds and time constants
  always_comb begin
    agc_en = agc_ctl_ff[AGC_EN_B];
    tgt_lvl = target_level(agc_ctl_ff[AGC_TGT_LSB +: 3]);
    thr_lo = noise_level(noise_sel_ff);
    thr_hi = thr_lo << hyst_ff;
    atk_period = 24'(32'(attack_ms(agc_ctl_ff[AGC_TIME_LSB +: 2])) * MS_CYCLES);
    dcy_period = 24'(32'(decay_ms(agc_ctl_ff[AGC_TIME_LSB+2 +: 2])) * MS_CYCLES);
    lim_ns = 9'h001 << deb_ns_ff;
    lim_sn = 9'h001 << deb_sn_ff;
    too_loud = (avg > tgt_lvl);
    too_weak = (avg < tgt_lvl);
    atk_due = (atk_cnt_ff >= atk_period);
    dcy_due = (dcy_cnt_ff >= dcy_period);
  end

  // attack and decay pacing: one half-dB step per elapsed time constant
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      atk_cnt_ff <= '0;
      dcy_cnt_ff <= '0;
    end else begin
      if (!too_loud || mode_ff != AGC_NORMAL || (fs_tick_ff && atk_due)) begin
        atk_cnt_ff <= '0;
      end else if (!atk_due) begin
        atk_cnt_ff <= atk_cnt_ff + 24'h00_0001;
      end
      if (!too_weak || mode_ff != AGC_NORMAL || (fs_tick_ff && dcy_due)) begin
        dcy_cnt_ff <= '0;
      end else if (!dcy_due) begin
        dcy_cnt_ff <= dcy_cnt_ff + 24'h00_0001;
      end
    end
  end

  // automatic gain loop, advanced once per output sample
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_ff <= AGC_NORMAL;
      agc_gain_ff <= '0;
      deb_ff <= '0;
      noise_flag_ff <= 1'b0;
      sat_ff <= 1'b0;
    end else if (!agc_en) begin
      mode_ff <= AGC_NORMAL;
      agc_gain_ff <= '0;
      deb_ff <= '0;
      noise_flag_ff <= 1'b0;
      sat_ff <= 1'b0;
    end else if (fs_tick_ff) begin
      unique case (mode_ff)
        AGC_NORMAL: begin
          if (avg < thr_lo) begin
            if (deb_ff + 9'h001 >= lim_ns) begin
              mode_ff <= AGC_SILENT;
              noise_flag_ff <= 1'b1;
              deb_ff <= '0;
            end else begin
              deb_ff <= deb_ff + 9'h001;
            end
          end else begin
            deb_ff <= '0;
          end
          if (agc_gain_ff > max_gain_ff) begin
            agc_gain_ff <= max_gain_ff;
          end else if (clip_en_ff && clip && agc_gain_ff != 7'h00) begin
            agc_gain_ff <= agc_gain_ff - 7'h01;
          end else if (too_loud && atk_due) begin
            sat_ff <= 1'b0;
            if (agc_gain_ff != 7'h00) begin
              agc_gain_ff <= agc_gain_ff - 7'h01;
            end
          end else if (too_weak && dcy_due) begin
            if (agc_gain_ff < max_gain_ff) begin
              agc_gain_ff <= agc_gain_ff + 7'h01;
              sat_ff <= 1'b0;
            end else begin
              sat_ff <= 1'b1;
            end
          end
        end
        AGC_SILENT: begin
          if (agc_gain_ff != 7'h00) begin
            agc_gain_ff <= agc_gain_ff - 7'h01;
          end
          if (avg > thr_hi) begin
            if (deb_ff + 9'h001 >= lim_sn) begin
              mode_ff <= AGC_NORMAL;
              noise_flag_ff <= 1'b0;
              deb_ff <= '0;
            end else begin
              deb_ff <= deb_ff + 9'h001;
            end
          end else begin
            deb_ff <= '0;
          end
        end
      endcase
    end
  end

  // gain request: out-of-range codes are held at the top of the range
  always_comb begin
    req_gain = (path_ff[PATH_GAIN_LSB +: 7] > GAIN_MAX) ? GAIN_MAX
             : path_ff[PATH_GAIN_LSB +: 7];
    if (path_ff[PATH_ADC_PD_B]) begin
      step_target = GAIN_MUTE;
    end else if (agc_en) begin
      step_target = {1'b0, agc_gain_ff} + 8'h01;
    end else begin
      step_target = {1'b0, req_gain} + 8'h01;
    end
  end

  assign step_if.tick = fs_tick_ff;
  assign step_if.two_per = path_ff[PATH_TWO_B];
  assign step_if.soft_off = soft_off_ff;
  assign step_if.target = step_target;

  // power sequencing: analog stays up until the ramp reaches mute
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pd_done_ff <= 1'b0;
      analog_en_ff <= 1'b0;
      mux_ff <= 2'h0;
      bias_en_ff <= 1'b0;
      bias_hi_ff <= 1'b0;
    end else begin
      pd_done_ff <= path_ff[PATH_ADC_PD_B] && (step_if.applied == GAIN_MUTE);
      analog_en_ff <= !(path_ff[PATH_ADC_PD_B] && (step_if.applied == GAIN_MUTE));
      mux_ff <= path_ff[PATH_SEL_LSB +: 2];
      bias_en_ff <= !(pd_done_ff && path_ff[PATH_MIX_PD_B]);
      bias_hi_ff <= path_ff[PATH_BIAS_B];
    end
  end

  assign o_rdata = rdata_ff;
  assign o_mux_sel = mux_ff;
  assign o_bias_en = bias_en_ff;
  assign o_bias_hi = bias_hi_ff;
  assign o_analog_en = analog_en_ff;
  assign o_pga_gain = step_if.applied;
  assign o_adc_pd_done = pd_done_ff;
endmodule : aagc_top
`default_nettype wire

// [hw/aagc_pkg.sv]
// constants, field layouts and lookup tables for the record-path gain and
// automatic gain loop controller; assumes a 10 MHz master clock and that the
// register offsets are those of the audio control page.
//
// Functional notes
// - with PLL on, reference rate is master*K/(2048*P), K = J.D, J 1..64.
// - input selector picks microphone, auxiliary, or both as a differential pair.
// - mic bias selectable 2 V or 2.5 V, off when converter and mixer are down.
// - amplifier gain accepted from 0 dB to 59.5 dB in 0.5 dB steps.
// - applied gain moves one 0.5 dB step per one or two output samples.
// - gain is muted after reset and ramps to mute before power-down completes.
// - status D0 of 04H is set while applied gain equals requested gain with the loop off; with the loop on it shows saturation.
// - D15 of 1DH set applies gain changes directly without stepping.
// - modulator stream is oversampled 128 times the output sample rate.
// - decimation from 128 Fs to Fs, linear phase, group delay 17 samples.
// - loop measures amplitude as the average of absolute sample values.
// - eight target levels from -5.5 dB to -24 dB, field D7-D5 of 01H.
// - loud input lowers gain at attack time 8..20 ms, field D2-D1 of 01H.
// - weak input raises gain at decay time 100..500 ms.
// - below noise threshold gain falls to 0 dB per sample and noise flag sets.
// - noise threshold -60 dB to -90 dB from field D5-D4 of 06H.
// - silence detection uses hysteresis and two debounce counts.
// - loop gain is clamped to the maximum in D15-D9 of 1EH at each sample in normal mode.
// - clip-stepping enable at D3 of 06H.
package aagc_pkg;
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned CLK_MHZ = 10;
  localparam int unsigned MS_US = 1000;
  localparam int unsigned MS_CYC = MS_US * CLK_MHZ;
  localparam logic [ADDR_W-1:0] ADDR_AGC = 6'h01;
  localparam logic [ADDR_W-1:0] ADDR_FLAGS = 6'h04;
  localparam logic [ADDR_W-1:0] ADDR_NOISE = 6'h06;
  localparam logic [ADDR_W-1:0] ADDR_SOFT = 6'h1D;
  localparam logic [ADDR_W-1:0] ADDR_DEB = 6'h1E;
  localparam logic [ADDR_W-1:0] ADDR_PATH = 6'h20;
  localparam logic [ADDR_W-1:0] ADDR_PLL = 6'h21;
  localparam logic [ADDR_W-1:0] ADDR_FRAC = 6'h22;
  // field positions
  localparam int AGC_EN_B = 0;
  localparam int AGC_TIME_LSB = 1;
  localparam int AGC_TGT_LSB = 5;
  localparam int AGC_GAIN_LSB = 8;
  localparam int FLG_SAT_B = 0;
  localparam int FLG_PD_B = 1;
  localparam int FLG_NOISE_B = 11;
  localparam int NZ_CLIP_B = 3;
  localparam int NZ_THR_LSB = 4;
  localparam int SOFT_HYST_LSB = 9;
  localparam int SOFT_OFF_B = 15;
  localparam int DEB_SN_LSB = 3;
  localparam int DEB_NS_LSB = 6;
  localparam int DEB_MAX_LSB = 9;
  localparam int PATH_GAIN_LSB = 0;
  localparam int PATH_TWO_B = 7;
  localparam int PATH_SEL_LSB = 8;
  localparam int PATH_BIAS_B = 10;
  localparam int PATH_ADC_PD_B = 11;
  localparam int PATH_MIX_PD_B = 12;
  localparam int PLL_EN_B = 0;
  localparam int PLL_P_LSB = 1;
  localparam int PLL_J_LSB = 5;
  localparam int PLL_Q_LSB = 12;
  localparam int FRAC_W = 14;
  // reset values
  localparam logic [DATA_W-1:0] RST_PATH = 16'h1800;
  localparam logic [DATA_W-1:0] RST_PLL = 16'h0022;
  // gain codes: 0 is mute, code n+1 is n half-dB steps
  localparam logic [7:0] GAIN_MUTE = 8'h00;
  localparam logic [6:0] GAIN_MAX = 7'h77;
  // clocking and conversion
  localparam int unsigned OSR = 128;
  localparam int unsigned PLL_DIV = 2048;
  localparam int unsigned FRAC_SCALE = 10000;
  localparam int unsigned Q_BIAS = 2;
  localparam int unsigned DECIM_DELAY = 17;
  localparam logic [7:0] ONES_MID = 8'h40;
  localparam logic [15:0] FULL_POS = 16'h7FFF;
  localparam logic [15:0] CLIP_LEVEL = 16'h7F00;
  localparam int unsigned AVG_SHIFT = 4;

  typedef enum logic [1:0] {
    AGC_NORMAL = 2'b01,
    AGC_SILENT = 2'b10
  } aagc_mode_t;

  function automatic logic [15:0] target_level(input logic [2:0] sel);
    case (sel)
      3'h0: target_level = 16'h43EE;
      3'h1: target_level = 16'h32F5;
      3'h2: target_level = 16'h287A;
      3'h3: target_level = 16'h2027;
      3'h4: target_level = 16'h198A;
      3'h5: target_level = 16'h1214;
      3'h6: target_level = 16'h0CCD;
      default: target_level = 16'h0813;
    endcase
  endfunction : target_level

  function automatic logic [15:0] noise_level(input logic [1:0] sel);
    case (sel)
      2'h0: noise_level = 16'h0021;
      2'h1: noise_level = 16'h000A;
      2'h2: noise_level = 16'h0003;
      default: noise_level = 16'h0001;
    endcase
  endfunction : noise_level

  // attack 8/12/16/20 ms and decay 100/200/300/500 ms, in milliseconds
  function automatic logic [9:0] attack_ms(input logic [1:0] sel);
    case (sel)
      2'h0: attack_ms = 10'h008;
      2'h1: attack_ms = 10'h00C;
      2'h2: attack_ms = 10'h010;
      default: attack_ms = 10'h014;
    endcase
  endfunction : attack_ms

  function automatic logic [9:0] decay_ms(input logic [1:0] sel);
    case (sel)
      2'h0: decay_ms = 10'h064;
      2'h1: decay_ms = 10'h0C8;
      2'h2: decay_ms = 10'h12C;
      default: decay_ms = 10'h1F4;
    endcase
  endfunction : decay_ms
endpackage : aagc_pkg

// [hw/aagc_step_if.sv]
// signals between the controller and the gain soft-stepper
// assumes both ends run on the same clock
`timescale 1ns/100ps
`default_nettype none
interface aagc_step_if;
  logic tick;
  logic two_per;
  logic soft_off;
  logic [7:0] target;
  logic [7:0] applied;
  logic settled;
  modport ctl(output tick, output two_per, output soft_off, output target,
              input applied, input settled);
  modport stp(input tick, input two_per, input soft_off, input target,
              output applied, output settled);
endinterface : aagc_step_if
`default_nettype wire

// [hw/aagc_stepper.sv]
// soft-stepping of the applied amplifier gain toward the requested code
// assumes tick is a one-cycle pulse per converter output sample
`timescale 1ns/100ps
`default_nettype none
module aagc_stepper (
  input wire logic i_clk,
  input wire logic i_rst_n,
  aagc_step_if.stp s
);
  logic [7:0] applied_ff;
  logic skip_ff;
  logic settled_ff;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      applied_ff <= 8'h00;
      skip_ff <= 1'b0;
    end else if (s.soft_off) begin
      applied_ff <= s.target;
      skip_ff <= 1'b0;
    end else if (s.tick) begin
      if (s.two_per && !skip_ff) begin
        skip_ff <= 1'b1;
      end else begin
        skip_ff <= 1'b0;
        if (applied_ff < s.target) begin
          applied_ff <= applied_ff + 8'h01;
        end else if (applied_ff > s.target) begin
          applied_ff <= applied_ff - 8'h01;
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      settled_ff <= 1'b0;
    end else begin
      settled_ff <= (applied_ff == s.target);
    end
  end

  assign s.applied = applied_ff;
  assign s.settled = settled_ff;
endmodule : aagc_stepper
`default_nettype wire

// [hw/aagc_absavg.sv]
// running average of absolute sample values and clip detect
// assumes i_valid is a one-cycle pulse per signed sample
`timescale 1ns/100ps
`default_nettype none
module aagc_absavg
  import aagc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_valid,
  input wire logic [15:0] i_sample,
  output logic [15:0] o_avg,
  output logic o_clip
);
  logic [19:0] acc_ff;
  logic clip_ff;
  logic [15:0] mag;

  // most negative sample maps to 16'h8000, which still fits unsigned
  assign mag = i_sample[15] ? 16'(~i_sample + 16'h0001) : i_sample;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc_ff <= 20'h0_0000;
      clip_ff <= 1'b0;
    end else if (i_valid) begin
      acc_ff <= acc_ff - (acc_ff >> AVG_SHIFT) + {4'h0, mag};
      clip_ff <= (mag >= CLIP_LEVEL);
    end
  end

  assign o_avg = acc_ff[AVG_SHIFT +: 16];
  assign o_clip = clip_ff;
endmodule : aagc_absavg
`default_nettype wire

// [tb/aagc_mod_model.sv]
// modulator bit source standing in for the analog record front end
// assumes i_density counts ones per 128 bits, 0 to 128
`timescale 1ns/100ps
`default_nettype none
module aagc_mod_model (
  input wire logic i_clk,
  input wire logic [7:0] i_density,
  output logic o_bit
);
  logic [6:0] acc_ff = 7'h00;
  logic ph_ff = 1'b0;
  // first-order shaping spreads the ones evenly over a frame; bits last two
  // clocks, one tick of the oversampling divider
  always @(posedge i_clk) begin
    ph_ff <= !ph_ff;
    if (ph_ff) begin
      {o_bit, acc_ff} <= {1'b0, acc_ff} + i_density;
    end
  end
endmodule : aagc_mod_model
`default_nettype wire

// [tb/aagc_chk.sv]
// port assertions for the record-path gain controller
// assumes one clock domain and an asynchronous active-low reset
`timescale 1ns/100ps
`default_nettype none
module aagc_chk #(
  parameter int unsigned MS_CYCLES = 4
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic [1:0] o_mux_sel,
  input wire logic o_bias_hi,
  input wire logic o_analog_en,
  input wire logic [7:0] o_pga_gain,
  input wire logic o_adc_pd_done,
  input wire logic [15:0] o_sample,
  input wire logic o_sample_valid
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  a_read_slot_only: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
    else $error("read data outside its slot");
  a_gain_code_range: assert property (o_pga_gain <= 8'h78)
    else $error("gain code above range");
  a_down_is_muted: assert property (o_adc_pd_done |-> o_pga_gain == 8'h00 && !o_analog_en)
    else $error("powered down but not muted");
  a_done_after_mute: assert property ($rose(o_adc_pd_done) |-> $past(o_pga_gain) == 8'h00)
    else $error("power-down before ramp ended");
  a_no_sample_down: assert property (o_adc_pd_done && $past(o_adc_pd_done) |-> !o_sample_valid)
    else $error("sample while powered down");
  a_valid_spacing: assert property (o_sample_valid |=> !o_sample_valid [*8])
    else $error("sample pulses too close");
  a_sample_held: assert property (!o_sample_valid |-> $stable(o_sample))
    else $error("sample moved without valid");
  a_select_by_write: assert property ($changed(o_mux_sel) || $changed(o_bias_hi) |-> $past(i_wr) || $past(i_wr, 2))
    else $error("selector moved without write");
  cover property ($rose(o_adc_pd_done));
  cover property ($fell(o_adc_pd_done));
  cover property (o_sample_valid ##1 !o_sample_valid);
endmodule : aagc_chk
bind aagc_top aagc_chk #(.MS_CYCLES(MS_CYCLES)) aagc_chk_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_mux_sel(o_mux_sel), .o_bias_hi(o_bias_hi),
  .o_analog_en(o_analog_en), .o_pga_gain(o_pga_gain), .o_adc_pd_done(o_adc_pd_done),
  .o_sample(o_sample), .o_sample_valid(o_sample_valid));
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench for the record-path gain controller
// assumes the reset state has the PLL off and a divide of two
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import aagc_pkg::*;
  logic i_clk, i_rst_n, i_wr, i_rd, rd_seen, m_bit, bias;
  logic o_bias_en, o_bias_hi, o_analog_en, o_adc_pd_done, o_sample_valid;
  logic [5:0] i_addr;
  logic [15:0] i_wdata, o_rdata, o_sample, rv, eq[$], mq[$], sq[$];
  logic [1:0] o_mux_sel, sel;
  logic [7:0] o_pga_gain, dens;
  int n_mismatch, checks, n;
  time t0;
  aagc_top #(.MS_CYCLES(4)) aagc_top_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_mod_bit(m_bit), .o_rdata(o_rdata),
    .o_mux_sel(o_mux_sel), .o_bias_en(o_bias_en), .o_bias_hi(o_bias_hi),
    .o_analog_en(o_analog_en), .o_pga_gain(o_pga_gain), .o_adc_pd_done(o_adc_pd_done),
    .o_sample(o_sample), .o_sample_valid(o_sample_valid));
  aagc_mod_model aagc_mod_model_inst (.i_clk(i_clk), .i_density(dens), .o_bit(m_bit));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [15:0] e, input logic [15:0] m);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    eq.push_back(e);
    mq.push_back(m);
    @(posedge i_clk);
    i_rd <= 1'b0;
  endtask : rd
  task automatic wait_gain(input logic [7:0] g);
    n = 0;
    while (o_pga_gain !== g && n < 40000) begin
      @(negedge i_clk);
      n++;
    end
    check({8'h00, o_pga_gain}, {8'h00, g});
  endtask : wait_gain
  function automatic logic [15:0] pw(input logic [1:0] pd, input logic st, input logic [6:0] g);
    pw = {3'b000, pd, bias, sel, st, g};
  endfunction : pw
  task automatic summarize();
    if (n_mismatch == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  always @(posedge i_clk) rd_seen <= i_rd;
  always @(negedge i_clk) begin
    if (rd_seen) check(o_rdata & mq.pop_front(), eq.pop_front());
    if (o_sample_valid && sq.size() > 0) check(o_sample, sq.pop_front());
  end
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  initial begin
    repeat (60000) @(posedge i_clk);
    n_mismatch++;
    summarize();
  end
  initial begin
    {i_rst_n, i_wr, i_rd, rd_seen, i_addr, i_wdata} = '0;
    dens = 8'h40;
    void'($urandom(32'h4550));
    rv = 16'($urandom());
    sel = 2'($urandom());
    bias = 1'($urandom());
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    rd(ADDR_FLAGS, 16'h0003, 16'hFFFF);
    rd(ADDR_PATH, 16'h1800, 16'hFFFF);
    rd(6'h3F, 16'h0000, 16'hFFFF);
    wr(ADDR_DEB, {7'h0A, 6'h00, rv[2:0]});
    rd(ADDR_DEB, 16'h1400, 16'hFFFF);
    wr(ADDR_NOISE, rv & 16'hFFCF);
    rd(ADDR_NOISE, rv & 16'h0008, 16'hFFFF);
    wr(ADDR_SOFT, rv & 16'h7FFF);
    rd(ADDR_SOFT, rv & 16'h0600, 16'hFFFF);
    wr(ADDR_FLAGS, 16'hFFFF);
    rd(ADDR_FLAGS, 16'h0003, 16'hFFFF);
    wr(ADDR_AGC, rv & 16'h00FE);
    rd(ADDR_AGC, rv & 16'h00FE, 16'hFFFF);
    wr(ADDR_PATH, pw(2'b00, 1'b0, 7'h28));
    wait_gain(8'h29);
    check({15'h0000, n >= 40 * 256 && n <= 42 * 256}, 16'h0001);
    check({12'h000, o_analog_en, o_bias_en, o_bias_hi, o_mux_sel[0]},
          {12'h000, 2'b11, bias, sel[0]});
    check({14'h0000, o_mux_sel}, {14'h0000, sel});
    wr(ADDR_PATH, pw(2'b00, 1'b1, 7'h14));
    wait_gain(8'h15);
    check({15'h0000, n >= 38 * 256 && n <= 41 * 256}, 16'h0001);
    wr(ADDR_SOFT, 16'h8000);
    wr(ADDR_PATH, pw(2'b00, 1'b0, 7'h64));
    repeat (3) @(posedge i_clk);
    check({8'h00, o_pga_gain}, 16'h0065);
    wr(ADDR_PATH, pw(2'b00, 1'b0, 7'h03));
    repeat (3) @(posedge i_clk);
    check({8'h00, o_pga_gain}, 16'h0004);
    wr(ADDR_SOFT, 16'h0000);
    wr(ADDR_AGC, (rv & 16'h00FE) | 16'h0001);
    repeat (30) @(posedge o_sample_valid);
    rd(ADDR_FLAGS, 16'h0800, 16'h0802);
    check({8'h00, o_pga_gain}, 16'h0001);
    wr(ADDR_AGC, rv & 16'h00FE);
    dens <= 8'h80;
    repeat (20) @(posedge o_sample_valid);
    sq.push_back(16'h7FFF);
    sq.push_back(16'h7FFF);
    repeat (2) @(posedge o_sample_valid);
    dens <= 8'h00;
    repeat (20) @(posedge o_sample_valid);
    sq.push_back(16'h8000);
    repeat (2) @(posedge o_sample_valid);
    wr(ADDR_PLL, 16'h0103);
    wr(ADDR_FRAC, 16'h1388);
    repeat (2) @(posedge o_sample_valid);
    t0 = $time;
    @(posedge o_sample_valid);
    check({15'h0000, ($time - t0) inside {[24000:24100]}}, 16'h0001);
    wr(ADDR_PATH, pw(2'b01, 1'b0, 7'h03));
    wait_gain(8'h00);
    repeat (3) @(posedge i_clk);
    check({13'h0000, o_adc_pd_done, o_analog_en, o_bias_en}, 16'h0005);
    wr(ADDR_PATH, pw(2'b11, 1'b0, 7'h03));
    repeat (3) @(posedge i_clk);
    check({13'h0000, o_adc_pd_done, o_analog_en, o_bias_en}, 16'h0004);
    summarize();
  end
endmodule : testbench
`default_nettype wire
